// ---- design/fcs_ctrl.sv ----
// Host-side command controller for a byte-wide parallel flash
//
// Rules from the flash datasheet
// R1 - Device complements toggle bit while busy
// R2 - Toggle advances per read strobe
// R3 - Two equal reads end it; read again
// R4 - Toggle valid only while engine runs
// R5 - Device ignores program to protected block
// R6 - Protected erase toggles briefly then reads
// R7 - Device flags failure on error bit
// R8 - Error bit holds until reset command
// R9 - Error bit low while successful op runs
// R10 - Stop using a block after error (only OP_WRITE to the block is refused; reads and polls to it still run)
// R11 - Erase window bit low until timeout
// R12 - Unlock pair: AA@5555 then 55@2AAA
// R13 - Address at falling, data at rising
// R14 - Device accepts unlock at two positions
// R15 - F0 alone or unlocked restores reads
// R16 - Wait 5us before read after reset (waits only when pdown or may_erase is set)
// R17 - Signature query: unlock then 90@5555
// R18 - Address bits pick maker or part code
// R19 - Protection query reads 01 or 00
// R20 - Power-down needs reset before anything else
// R21 - Protection query only through signature mode
// R22 - Completion bit low until erase ends
// R23 - Device aborts on bad unlock or confirm
// R24 - Power-down code is a parameter
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module fcs_ctrl
  import fcs_pkg::*;
#(
  parameter logic [7:0] PD_CODE = 8'h00 // R24
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Flash pins
  output fcs_pins_t flash_pins,
  input wire logic [7:0] flash_dq_i
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_UNLK1 = 4'b0001,
    S_UNLK2 = 4'b0011,
    S_CMD = 4'b0010,
    S_READ = 4'b0110,
    S_PA = 4'b0111,
    S_PB = 4'b0101,
    S_FIN = 4'b0100,
    S_WAIT = 4'b1100
  } fcs_state_t;

  fcs_state_t state, next_state;
  fcs_op_t op, next_op, new_op;
  logic launched, next_launched;
  logic [9:0] cnt, next_cnt;
  logic [7:0] prev, next_prev;
  logic err_seen, next_err_seen;
  logic error, next_error;
  logic refused, next_refused;
  logic prot, next_prot;
  logic pdown, next_pdown;
  logic sig, next_sig;
  logic may_erase, next_may_erase;
  logic [7:0] bad, next_bad;
  logic [7:0] rdata, next_rdata;
  logic [18:0] addr, next_addr;
  logic [7:0] wdata, next_wdata;
  logic cyc_start, cyc_wr, cyc_done;
  logic [18:0] cyc_addr;
  logic [7:0] cyc_wdata, cyc_rdata;
  logic launch, rd_ack, next_rd_ack;
  logic [31:0] next_readdata;

  function automatic logic is_reset(input fcs_op_t o);
    return (o == OP_RESET) || (o == OP_RESET_UNLK);
  endfunction : is_reset

  fcs_cycle u_cycle (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(cyc_start),
    .wr(cyc_wr),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(flash_pins),
    .dq_i(flash_dq_i)
  );

  assign new_op = fcs_op_t'(avs_writedata[2:0]);
  assign launch = avs_write && (avs_address == REG_CMD) && (state == S_IDLE);
  // Command writes stall while a sequence runs rather than being dropped
  assign avs_waitrequest = (avs_read && !rd_ack) ||
                           (avs_write && (avs_address == REG_CMD) && (state != S_IDLE));

  always_comb begin
    next_state = state;
    next_op = op;
    next_launched = launched;
    next_cnt = cnt;
    next_prev = prev;
    next_err_seen = err_seen;
    next_error = error;
    next_refused = refused;
    next_prot = prot;
    next_pdown = pdown;
    next_sig = sig;
    next_may_erase = may_erase;
    next_bad = bad;
    next_rdata = rdata;
    next_addr = addr;
    next_wdata = wdata;
    cyc_start = 1'b0;
    cyc_wr = 1'b0;
    cyc_addr = addr;
    cyc_wdata = wdata;
    if (avs_write && (avs_address == REG_ADDR)) next_addr = avs_writedata[18:0];
    if (avs_write && (avs_address == REG_WDATA)) next_wdata = avs_writedata[7:0];
    if (avs_write && (avs_address == REG_STATUS) && avs_writedata[ST_REFUSED]) next_refused = 1'b0;
    // Sequence steps: each issues one pin cycle, then waits for it
    unique case (state)
      S_UNLK1: begin
        cyc_wr = 1'b1;
        cyc_addr = UNLOCK_ADDR_1; // R12
        cyc_wdata = UNLOCK_DATA_1;
      end
      S_UNLK2: begin
        cyc_wr = 1'b1;
        cyc_addr = UNLOCK_ADDR_2; // R12
        cyc_wdata = UNLOCK_DATA_2;
      end
      S_CMD: begin
        cyc_wr = 1'b1;
        cyc_addr = CMD_ADDR;
        if (is_reset(op)) cyc_wdata = READ_ARRAY_CMD; // R15
        else if (op == OP_PDOWN) cyc_wdata = PD_CODE; // R20
        else if (op == OP_WRITE) cyc_addr = addr;
        else cyc_wdata = SIGNATURE_QUERY_CMD; // R17
      end
      S_READ: begin
        // Block number on the top lines, A1 high, A0 and A6 low
        if (op == OP_PROT) cyc_addr = {addr[18:16], PROT_QUERY_LOW}; // R21
      end
      default: begin
      end
    endcase
    if (state != S_IDLE && state != S_WAIT) begin
      if (!launched) begin
        cyc_start = 1'b1;
        next_launched = 1'b1;
      end else if (cyc_done) begin
        next_launched = 1'b0;
      end
    end
    unique case (state)
      S_IDLE: begin
        if (launch) begin
          next_op = new_op;
          next_err_seen = 1'b0;
          if (pdown && !is_reset(new_op)) begin
            next_refused = 1'b1; // R20
          end else if (new_op == OP_WRITE && bad[addr[18:16]]) begin
            next_refused = 1'b1; // R10
          end else begin
            unique case (new_op)
              OP_RESET, OP_PDOWN, OP_WRITE: next_state = S_CMD;
              OP_RESET_UNLK, OP_SIG, OP_PROT: next_state = S_UNLK1; // R12
              OP_READ: next_state = S_READ;
              OP_POLL: next_state = S_PA;
            endcase
          end
        end
      end
      S_UNLK1: if (launched && cyc_done) next_state = S_UNLK2;
      S_UNLK2: if (launched && cyc_done) next_state = S_CMD;
      S_CMD: begin
        if (launched && cyc_done) begin
          next_state = S_IDLE;
          if (is_reset(op)) begin
            next_error = 1'b0; // R8
            next_sig = 1'b0;
            next_pdown = 1'b0;
            next_may_erase = 1'b0;
            next_cnt = 10'h000;
            if (pdown || may_erase) next_state = S_WAIT; // R16
          end else if (op == OP_PDOWN) begin
            next_pdown = 1'b1; // R20
          end else if (op == OP_WRITE) begin
            next_may_erase = 1'b1;
          end else begin
            next_state = S_READ; // R17
          end
        end
      end
      S_READ: begin
        if (launched && cyc_done) begin
          next_rdata = cyc_rdata;
          next_state = S_IDLE;
          if (op == OP_SIG || op == OP_PROT) next_sig = 1'b1;
          if (op == OP_PROT) next_prot = cyc_rdata[0];
        end
      end
      S_PA: begin
        if (launched && cyc_done) begin
          next_prev = cyc_rdata;
          next_state = S_PB;
        end
      end
      S_PB: begin
        if (launched && cyc_done) begin
          if (cyc_rdata[TOGGLE_STATUS_BIT] == prev[TOGGLE_STATUS_BIT]) begin
            next_state = S_FIN; // R3
          end else if (cyc_rdata[ERROR_STATUS_BIT]) begin
            // A still-toggling pair after the error bit rose means failure
            if (err_seen) begin
              next_error = 1'b1;
              next_bad[addr[18:16]] = 1'b1; // R10
              next_may_erase = 1'b0;
              next_rdata = cyc_rdata;
              next_state = S_IDLE;
            end else begin
              next_err_seen = 1'b1;
              next_state = S_PA;
            end
          end else begin
            next_state = S_PA;
          end
        end
      end
      S_FIN: begin
        if (launched && cyc_done) begin
          next_rdata = cyc_rdata; // R3
          next_may_erase = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_WAIT: begin
        if (cnt == 10'(WAIT_CYC - 1)) next_state = S_IDLE; // R16
        else next_cnt = cnt + 10'h001;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      op <= OP_RESET;
      launched <= 1'b0;
      cnt <= 10'h000;
      prev <= 8'h00;
      err_seen <= 1'b0;
      error <= 1'b0;
      refused <= 1'b0;
      prot <= 1'b0;
      pdown <= 1'b0;
      sig <= 1'b0;
      may_erase <= 1'b0;
      bad <= 8'h00;
      rdata <= 8'h00;
      addr <= 19'h00000;
      wdata <= 8'h00;
    end else begin
      state <= next_state;
      op <= next_op;
      launched <= next_launched;
      cnt <= next_cnt;
      prev <= next_prev;
      err_seen <= next_err_seen;
      error <= next_error;
      refused <= next_refused;
      prot <= next_prot;
      pdown <= next_pdown;
      sig <= next_sig;
      may_erase <= next_may_erase;
      bad <= next_bad;
      rdata <= next_rdata;
      addr <= next_addr;
      wdata <= next_wdata;
    end
  end

  // Register read path, one wait cycle per read
  always_comb begin
    next_rd_ack = avs_read && !rd_ack;
    next_readdata = avs_readdata;
    if (avs_read && !rd_ack) begin
      unique case (avs_address)
        REG_CMD: next_readdata = {29'h0, op};
        REG_ADDR: next_readdata = {13'h0, addr};
        REG_WDATA: next_readdata = {24'h0, wdata};
        REG_STATUS: next_readdata = {26'h0, sig, pdown, refused, prot, error,
                                     state != S_IDLE};
        REG_RDATA: next_readdata = {24'h0, rdata};
        REG_BAD: next_readdata = {24'h0, bad};
        default: next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_ack <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      rd_ack <= next_rd_ack;
      avs_readdata <= next_readdata;
    end
  end

  a_unlock_first: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    cyc_start && state == S_UNLK1 |-> cyc_addr == 19'h05555 && cyc_wdata == 8'hAA)
    else $error("first unlock write wrong");
  a_unlock_order: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    $rose(state == S_CMD) && $past(state) == S_UNLK2 |-> $past(cyc_done)
      && $past(cyc_addr) == 19'h02AAA && $past(cyc_wdata) == 8'h55)
    else $error("second unlock write wrong");
  a_poll_pair: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
    state == S_PB && launched && cyc_done && cyc_rdata[6] == prev[6]
      |=> state == S_FIN && cyc_start)
    else $error("equal pair did not lead to final read");
  a_bad_block: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    launch && new_op == OP_WRITE && bad[addr[18:16]] && !pdown
      |=> state == S_IDLE && refused && !cyc_start)
    else $error("write to failed block not refused");
  a_reset_wait: assert property (@(posedge clk_sys) disable iff (!rst_n) // R16
    $rose(state == S_WAIT) |-> (state == S_WAIT && !cyc_start)[*8])
    else $error("read issued during reset wait");
  a_wait_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // R16
    $fell(state == S_WAIT) |-> $past(cnt) == 10'(WAIT_CYC - 1))
    else $error("reset wait ended early");
  a_sig_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
    cyc_start && state == S_CMD && (op == OP_SIG || op == OP_PROT)
      |-> cyc_wr && cyc_addr == 19'h05555 && cyc_wdata == 8'h90)
    else $error("signature command wrong");
  a_pdown_refuse: assert property (@(posedge clk_sys) disable iff (!rst_n) // R20
    launch && pdown && !is_reset(new_op) |=> state == S_IDLE && refused)
    else $error("operation accepted in power-down");
  a_prot_addr: assert property (@(posedge clk_sys) disable iff (!rst_n) // R21
    cyc_start && state == S_READ && op == OP_PROT
      |-> !cyc_wr && cyc_addr[1:0] == 2'b10 && !cyc_addr[6] && $past(state) != S_IDLE)
    else $error("protection query outside signature mode");
endmodule : fcs_ctrl

// ---- design/fcs_cycle.sv ----
// One read or write bus cycle on the flash pins
`timescale 1ns/1ns
module fcs_cycle
  import fcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Cycle request
  input wire logic start,
  input wire logic wr,
  input wire logic [18:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  // Flash pins
  output fcs_pins_t pins,
  input wire logic [7:0] dq_i
);
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_SET = 2'b01, C_ACT = 2'b11, C_REC = 2'b10} fcs_cst_t;
  fcs_cst_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [7:0] next_rdata;
  fcs_pins_t next_pins;
  logic next_done;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rdata = rdata;
    next_pins = pins;
    next_done = 1'b0;
    unique case (state)
      C_IDLE: begin
        if (start) begin
          // Address and data settle a cycle before any strobe falls
          next_pins = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: addr, dq_o: wdata, dq_oe: wr}; // R13
          next_state = C_SET;
        end
      end
      C_SET: begin
        next_pins.ce_n = 1'b0;
        next_pins.we_n = ~pins.dq_oe;
        next_pins.oe_n = pins.dq_oe;
        next_cnt = pins.dq_oe ? 5'(WP_CYC - 1) : 5'(ACC_CYC - 1);
        next_state = C_ACT;
      end
      C_ACT: begin
        if (cnt == 5'h00) begin
          if (!pins.dq_oe) next_rdata = dq_i;
          // Data stays driven past the rising strobe
          next_pins.ce_n = 1'b1; // R13
          next_pins.we_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_cnt = 5'(WPH_CYC - 1);
          next_state = C_REC;
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      C_REC: begin
        if (cnt == 5'h00) begin
          next_pins.dq_oe = 1'b0;
          next_done = 1'b1;
          next_state = C_IDLE;
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= C_IDLE;
      cnt <= 5'h00;
      rdata <= 8'h00;
      pins <= PINS_IDLE;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rdata <= next_rdata;
      pins <= next_pins;
      done <= next_done;
    end
  end

  a_strobe_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    $rose(pins.we_n) |-> $stable(pins.addr) && $stable(pins.dq_o) && pins.dq_oe)
    else $error("write strobe rose without stable address and data");
endmodule : fcs_cycle

// ---- design/fcs_pkg.sv ----
// Shared constants, types and timing for the flash command controller
package fcs_pkg;
  // Clock and pin timing, slowest grade
  localparam int CLK_MHZ = 125;
  localparam int T_WP_NS = 80;
  localparam int T_WPH_NS = 35;
  localparam int T_ACC_NS = 200;
  localparam int T_RST_WAIT_NS = 5000;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int WAIT_CYC = (T_RST_WAIT_NS * CLK_MHZ + 999) / 1000;

  // Register byte offsets
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam logic [4:0] REG_RDATA = 5'h10;
  localparam logic [4:0] REG_BAD = 5'h14;

  // Status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_ERROR = 1;
  localparam int ST_PROT = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_PDOWN = 4;
  localparam int ST_SIG = 5;

  // Device data bits
  localparam int TOGGLE_STATUS_BIT = 6;
  localparam int ERROR_STATUS_BIT = 5;

  // Unlock pair and command codes
  localparam logic [18:0] UNLOCK_ADDR_1 = 19'h05555;
  localparam logic [18:0] UNLOCK_ADDR_2 = 19'h02AAA;
  localparam logic [7:0] UNLOCK_DATA_1 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA_2 = 8'h55;
  localparam logic [18:0] CMD_ADDR = 19'h05555;
  localparam logic [7:0] READ_ARRAY_CMD = 8'hF0;
  localparam logic [7:0] SIGNATURE_QUERY_CMD = 8'h90;
  localparam logic [15:0] PROT_QUERY_LOW = 16'h0002;

  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_RESET_UNLK = 3'h1,
    OP_SIG = 3'h2,
    OP_PROT = 3'h3,
    OP_PDOWN = 3'h4,
    OP_READ = 3'h5,
    OP_WRITE = 3'h6,
    OP_POLL = 3'h7
  } fcs_op_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [18:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
  } fcs_pins_t;

  localparam fcs_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      addr: 19'h00000, dq_o: 8'h00, dq_oe: 1'b0};
endpackage : fcs_pkg

// ---- tb/fcs_flash_model.sv ----
// Behavioural model of the byte-wide flash device on the far side
`timescale 1ns/1ns
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [7:0] PD_CODE = 8'h00,
  parameter logic [7:0] PROG_CODE = 8'hA0,
  parameter logic [7:0] ERASE_CODE = 8'h80,
  parameter logic [7:0] CHIP_CODE = 8'h10,
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'hC3, // Arbitrary value
  parameter int BUSY_READS = 3
) (
  // Pins from the controller
  input wire fcs_pins_t pins,
  // Test controls
  input wire logic [7:0] prot,
  input wire logic fail,
  // Data toward the controller
  output logic [7:0] dq
);
  logic [7:0] mem [logic [18:0]];
  logic [18:0] a_lat, pa;
  logic [7:0] pd, v, d;
  logic wstb, rstb, sig, pdn, busy, err, tog, ers;
  int step, cnt;
  assign wstb = pins.ce_n | pins.we_n;
  assign rstb = pins.ce_n | pins.oe_n;
  initial begin
    {sig, pdn, busy, err, tog, ers} = 6'h00;
    step = 0;
    cnt = 0;
    v = 8'h00;
    dq = 8'h00;
  end
  function automatic logic [7:0] arr(input logic [18:0] ad);
    return mem.exists(ad) ? mem[ad] : 8'hFF;
  endfunction : arr
  always @(negedge wstb) a_lat = pins.addr;
  always @(posedge wstb) begin
    d = pins.dq_o;
    if (busy || pdn) begin
      // Only the reset code is heard here
      if (d == READ_ARRAY_CMD) begin
        {busy, ers, err, pdn, sig} = 5'h00;
        step = 0;
      end
    end else if (d == READ_ARRAY_CMD && step != 3) begin
      sig = 1'b0;
      step = 0;
    end else begin
      case (step)
        0: begin
          step = (a_lat == UNLOCK_ADDR_1 && d == UNLOCK_DATA_1) ? 1 : 0;
          // Power-down is a single write, no unlock needed
          if (a_lat == CMD_ADDR && d == PD_CODE) pdn = 1'b1;
        end
        1: step = (a_lat == UNLOCK_ADDR_2 && d == UNLOCK_DATA_2) ? 2 : 0;
        2: begin
          step = (a_lat != CMD_ADDR) ? 0 : (d == PROG_CODE) ? 3 : (d == ERASE_CODE) ? 4 : 0;
          if (a_lat == CMD_ADDR && d == SIGNATURE_QUERY_CMD) sig = 1'b1;
          if (a_lat == CMD_ADDR && d == PD_CODE) pdn = 1'b1;
        end
        3: begin
          step = 0;
          if (!prot[a_lat[18:16]]) begin
            busy = 1'b1;
            pa = a_lat;
            pd = d;
            cnt = BUSY_READS;
            err = fail;
          end
        end
        4: step = (a_lat == UNLOCK_ADDR_1 && d == UNLOCK_DATA_1) ? 5 : 0;
        5: step = (a_lat == UNLOCK_ADDR_2 && d == UNLOCK_DATA_2) ? 6 : 0;
        default: begin
          step = 0;
          if (a_lat == CMD_ADDR && d == CHIP_CODE) begin
            {busy, ers, err} = {2'b11, fail};
            pd = 8'hFF;
            cnt = BUSY_READS;
          end
        end
      endcase
    end
  end
  always @(negedge rstb) begin
    if (busy) begin
      // Chip erase starts at once, so the window bit is high while it runs
      v = {~pd[7], tog, err, 1'b0, ers, 3'h0};
      tog = ~tog;
      if (!err) begin
        cnt--;
        if (cnt == 0) begin
          // Protected blocks never hold written data here, so a full wipe is exact
          if (!ers) mem[pa] = arr(pa) & pd;
          else if (prot != 8'hFF) mem.delete();
          {busy, ers} = 2'b00;
        end
      end
    end else if (sig) begin
      case ({pins.addr[6], pins.addr[1], pins.addr[0]})
        3'b000: v = MAKER_ID;
        3'b001: v = PART_ID;
        3'b010: v = {7'h00, prot[pins.addr[18:16]]};
        default: v = 8'h00;
      endcase
    end else begin
      v = arr(pins.addr);
    end
    dq <= #150 v;
  end
  // Released bus shows the inverse, never the stale byte
  always @(posedge rstb) dq <= #20 ~v;
endmodule : fcs_flash_model

// ---- tb/testbench.sv ----
// Self-checking bench for the flash command controller
`timescale 1ns/1ns
module testbench;
  import fcs_pkg::*;
  localparam logic [7:0] PD = 8'hB9; // Arbitrary power-down byte
  localparam logic [7:0] MK = 8'h5A; // Arbitrary value
  localparam logic [7:0] PT = 8'hC3; // Arbitrary value
  localparam logic [7:0] PROT = 8'h24;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic fail = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest;
  fcs_pins_t flash_pins;
  logic [7:0] m_dq, flash_dq_i, d;
  logic [18:0] a;
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'h3e6a6195;
  always #4 clk_sys = ~clk_sys;
  assign flash_dq_i = flash_pins.dq_oe ? flash_pins.dq_o : m_dq;
  fcs_ctrl #(.PD_CODE(PD)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_pins(flash_pins), .flash_dq_i(flash_dq_i));
  fcs_flash_model #(.PD_CODE(PD), .MAKER_ID(MK), .PART_ID(PT)) flash (.pins(flash_pins),
    .prot(PROT), .fail(fail), .dq(m_dq));
  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(posedge clk_sys);
    // Only the watchdog ends a stalled transfer
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic op(input logic [2:0] c, input logic [18:0] ad, input logic [7:0] dt);
    bus(1'b1, REG_ADDR, {13'h0, ad}, q);
    bus(1'b1, REG_WDATA, {24'h0, dt}, q);
    bus(1'b1, REG_CMD, {29'h0, c}, q);
    q = 32'h1;
    while (q[ST_BUSY] !== 1'b0) bus(1'b0, REG_STATUS, 32'h0, q);
  endtask : op
  task automatic rchk(input string nm, input logic [4:0] r, input logic [31:0] exp);
    bus(1'b0, r, 32'h0, q);
    chk(nm, exp, q);
  endtask : rchk
  task automatic sbit(input string nm, input int b, input logic exp);
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(nm, {31'h0, exp}, {31'h0, q[b]});
  endtask : sbit
  task automatic prog(input logic [18:0] ad, input logic [7:0] dt);
    op(OP_WRITE, UNLOCK_ADDR_1, UNLOCK_DATA_1);
    op(OP_WRITE, UNLOCK_ADDR_2, UNLOCK_DATA_2);
    op(OP_WRITE, CMD_ADDR, 8'hA0);
    op(OP_WRITE, ad, dt);
    op(OP_POLL, ad, 8'h00);
  endtask : prog
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rchk("status", REG_STATUS, 32'h0);
    rchk("unmapped", 5'h1C, 32'h0);
    op(OP_SIG, 19'h0, 8'h00);
    sbit("sig_mode", ST_SIG, 1'b1);
    op(OP_READ, 19'h00000, 8'h00);
    rchk("maker", REG_RDATA, {24'h0, MK});
    op(OP_READ, 19'h00001, 8'h00);
    rchk("part", REG_RDATA, {24'h0, PT});
    for (int b = 0; b < 8; b++) begin
      op(OP_PROT, {b[2:0], 16'h0}, 8'h00);
      rchk("prot", REG_RDATA, {31'h0, PROT[b]});
      sbit("prot_flag", ST_PROT, PROT[b]);
    end
    op(OP_RESET, 19'h0, 8'h00);
    op(OP_READ, 19'h12345, 8'h00);
    rchk("array", REG_RDATA, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      // Random byte in block 3 or 7, both unprotected
      a = 19'(($random(seed) & 32'h7FFF0) | 32'h30000 | i);
      d = 8'($random(seed));
      prog(a, d);
      rchk("poll_data", REG_RDATA, {24'h0, d});
      sbit("no_error", ST_ERROR, 1'b0);
      op(OP_READ, a, 8'h00);
      rchk("readback", REG_RDATA, {24'h0, d});
    end
    prog(19'h20100, 8'h00);
    op(OP_READ, 19'h20100, 8'h00);
    rchk("protected", REG_RDATA, 32'hFF);
    op(OP_WRITE, UNLOCK_ADDR_1, UNLOCK_DATA_1);
    op(OP_WRITE, 19'h02AAB, UNLOCK_DATA_2);
    op(OP_WRITE, CMD_ADDR, SIGNATURE_QUERY_CMD);
    op(OP_READ, 19'h00000, 8'h00);
    rchk("abort", REG_RDATA, 32'hFF);
    fail <= 1'b1;
    prog(19'h70000, 8'h00);
    sbit("error", ST_ERROR, 1'b1);
    bus(1'b0, REG_BAD, 32'h0, q);
    chk("bad_block", 32'h1, {31'h0, q[7]});
    op(OP_WRITE, 19'h70004, 8'h11);
    sbit("refused", ST_REFUSED, 1'b1);
    bus(1'b1, REG_STATUS, 32'h8, q);
    sbit("refuse_clr", ST_REFUSED, 1'b0);
    fail <= 1'b0;
    op(OP_RESET_UNLK, 19'h0, 8'h00);
    sbit("error_clr", ST_ERROR, 1'b0);
    op(OP_PDOWN, 19'h0, 8'h00);
    sbit("pdown", ST_PDOWN, 1'b1);
    op(OP_READ, a, 8'h00);
    sbit("pd_refused", ST_REFUSED, 1'b1);
    op(OP_RESET, 19'h0, 8'h00);
    sbit("pd_left", ST_PDOWN, 1'b0);
    op(OP_READ, a, 8'h00);
    rchk("after_pd", REG_RDATA, {24'h0, d});
    // Chip erase: unlock, setup, unlock again at cycles four and five, confirm
    for (int k = 0; k < 2; k++) begin
      op(OP_WRITE, UNLOCK_ADDR_1, UNLOCK_DATA_1);
      op(OP_WRITE, UNLOCK_ADDR_2, UNLOCK_DATA_2);
      op(OP_WRITE, CMD_ADDR, k ? 8'h10 : 8'h80);
    end
    op(OP_POLL, a, 8'h00);
    rchk("erased", REG_RDATA, 32'hFF);
    final_report();
  end
endmodule : testbench
